// >>> tci_pkg.sv
// Package of constants for the transmit cell insertion interrupt block
package tci_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [15:0] IDX_BLK_STAT_HI = 16'h0012;
  localparam logic [15:0] IDX_BLK_STAT_LO = 16'h0013;
  localparam logic [15:0] IDX_BLK_EN_LO = 16'h0017;
  localparam logic [15:0] IDX_CH_INDICATOR = 16'h0122;
  // Per-channel registers sit at index 0xNF0B / 0xNF0F, N = channel + 1
  localparam logic [11:0] IDX_CH_STAT_LOW = 12'hF0B;
  localparam logic [11:0] IDX_CH_EN_LOW = 12'hF0F;
  localparam logic [3:0] CH_NIBBLE_FIRST = 4'h1;
  localparam logic [3:0] CH_NIBBLE_LAST = 4'h4;

  // Geometry
  localparam int CH_NUM = 4;
  localparam int SRC_NUM = 6;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 17;

  // Block enable / status byte 0 field positions
  localparam int BLK_RX_ATM_BIT = 7;
  localparam int BLK_RX_TOH_BIT = 6;
  localparam int BLK_RX_POH_BIT = 5;
  localparam int BLK_RX_PPP_BIT = 4;
  localparam int BLK_TX_ATM_BIT = 3;
  localparam int BLK_TX_PPP_BIT = 0;
  // Block status byte 1 field position
  localparam int BLK_OP_CTRL_BIT = 7;

  // Per-channel enable / status field positions
  localparam int CH_EXT_BIT = 5;
  localparam int CH_INS_BIT = 4;
  localparam int CH_EXT_OVF_BIT = 3;
  localparam int CH_INS_OVF_BIT = 2;
  localparam int CH_HEC_BIT = 1;
  localparam int CH_PAR_BIT = 0;

  // Writable bit masks and values after reset
  localparam logic [7:0] BLK_EN_RW_MASK = 8'hF9;
  localparam logic [7:0] BLK_EN_RST = 8'h00;
  localparam logic [5:0] CH_EN_RST = 6'h00;
  localparam logic [5:0] CH_ST_RST = 6'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> tci_chan.sv
// One transmit ATM channel: source enables, sticky clear-on-read status
`timescale 1ns/1ps
`default_nettype none

module tci_chan (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Event pulses, bit layout as the status register
  input wire logic [5:0] evt,
  // Register access
  input wire logic en_wr,
  input wire logic [5:0] en_wdata,
  input wire logic st_rd,
  output logic [7:0] en_rdata,
  output logic [7:0] st_rdata,
  // Enabled cause pending
  output logic chan_irq
);

  logic [5:0] en_q;
  logic [5:0] en_d;
  logic [5:0] st_q;
  logic [5:0] st_d;

  // Source enable register, bits 7:6 read as zero
  assign en_d = en_wr ? en_wdata : en_q;

  // Set wins over the read clear so an event in the read cycle survives
  assign st_d = (st_q & ~{6{st_rd}}) | evt;

  // Pending only when the cause is enabled at source level
  assign chan_irq = |(st_q & en_q);

  assign en_rdata = {2'h0, en_q};
  assign st_rdata = {2'h0, st_q};

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= tci_pkg::CH_EN_RST;
      st_q <= tci_pkg::CH_ST_RST;
    end else begin
      en_q <= en_d;
      st_q <= st_d;
    end
  end

endmodule

`default_nettype wire

// >>> tci_top.sv
// Transmit ATM interrupt enable/status block with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tci_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Per-channel event pulses from the cell processor, bit n for channel n
  input wire logic [3:0] ext_evt,
  input wire logic [3:0] ins_evt,
  input wire logic [3:0] ext_ovf_evt,
  input wire logic [3:0] ins_ovf_evt,
  input wire logic [3:0] hec_err_evt,
  input wire logic [3:0] par_err_evt,
  // Status levels of the neighbouring blocks, same clock
  input wire logic op_ctrl_irq,
  input wire logic [4:0] other_blk_irq,
  // Interrupt to the processor
  output logic irq
);

  // Write channel holding registers
  logic aw_held_q;
  logic [15:0] aw_idx_q;
  logic w_held_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  // Read channel registers
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  // Block enable byte 0
  logic [7:0] blk_en_q;
  logic [7:0] blk_en_d;
  // Interrupt output register
  logic irq_q;

  // Bus handshake terms
  wire aw_take;
  wire w_take;
  wire do_wr;
  wire ar_take;
  wire [15:0] ar_idx;
  // Write decode
  wire wr_blk_en;
  wire wr_ch_hit;
  wire wr_ch_en;
  wire [3:0] wr_ch_nib;
  wire [1:0] wr_ch_sel;
  wire wr_mapped;
  wire wr_ok;
  // Read decode
  wire rd_ch_hit;
  wire [3:0] rd_ch_nib;
  wire [1:0] rd_ch_sel;
  wire rd_ch_st;
  wire rd_ch_en;
  wire rd_blk_hi;
  wire rd_blk_lo;
  wire rd_blk_en;
  wire rd_ind;
  wire rd_mapped;
  wire [7:0] rd_byte;
  // Channel results
  wire [3:0] chan_irq;
  wire [7:0] ch_en_rd [tci_pkg::CH_NUM];
  wire [7:0] ch_st_rd [tci_pkg::CH_NUM];
  // Block level status
  wire tx_atm_src;
  wire [7:0] blk_stat_lo;
  wire [7:0] blk_stat_hi;
  wire [7:0] ch_indicator;
  wire irq_d;

  // Handshakes: one write and one read at a time
  assign awready = !aw_held_q && !bvalid_q;
  assign wready = !w_held_q && !bvalid_q;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign do_wr = aw_held_q && w_held_q;
  assign arready = !rvalid_q;
  assign ar_take = arvalid && arready;
  assign ar_idx = araddr[tci_pkg::IDX_MSB:tci_pkg::IDX_LSB];
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Write decode on the held address
  assign wr_ch_nib = aw_idx_q[15:12];
  assign wr_ch_hit = (wr_ch_nib >= tci_pkg::CH_NIBBLE_FIRST)
                     && (wr_ch_nib <= tci_pkg::CH_NIBBLE_LAST);
  assign wr_ch_sel = 2'(wr_ch_nib - tci_pkg::CH_NIBBLE_FIRST);
  assign wr_blk_en = aw_idx_q == tci_pkg::IDX_BLK_EN_LO;
  assign wr_ch_en = wr_ch_hit && (aw_idx_q[11:0] == tci_pkg::IDX_CH_EN_LOW);
  // Read-only registers accept a write silently with OKAY
  assign wr_mapped = wr_blk_en || wr_ch_en
                     || (aw_idx_q == tci_pkg::IDX_BLK_STAT_HI)
                     || (aw_idx_q == tci_pkg::IDX_BLK_STAT_LO)
                     || (aw_idx_q == tci_pkg::IDX_CH_INDICATOR)
                     || (wr_ch_hit && (aw_idx_q[11:0] == tci_pkg::IDX_CH_STAT_LOW));
  // Only byte lane 0 carries register data
  assign wr_ok = do_wr && wlane_q;

  // Read decode on the offered address
  assign rd_ch_nib = ar_idx[15:12];
  assign rd_ch_hit = (rd_ch_nib >= tci_pkg::CH_NIBBLE_FIRST)
                     && (rd_ch_nib <= tci_pkg::CH_NIBBLE_LAST);
  assign rd_ch_sel = 2'(rd_ch_nib - tci_pkg::CH_NIBBLE_FIRST);
  assign rd_ch_st = rd_ch_hit && (ar_idx[11:0] == tci_pkg::IDX_CH_STAT_LOW);
  assign rd_ch_en = rd_ch_hit && (ar_idx[11:0] == tci_pkg::IDX_CH_EN_LOW);
  assign rd_blk_hi = ar_idx == tci_pkg::IDX_BLK_STAT_HI;
  assign rd_blk_lo = ar_idx == tci_pkg::IDX_BLK_STAT_LO;
  assign rd_blk_en = ar_idx == tci_pkg::IDX_BLK_EN_LO;
  assign rd_ind = ar_idx == tci_pkg::IDX_CH_INDICATOR;
  assign rd_mapped = rd_ch_st || rd_ch_en || rd_blk_hi || rd_blk_lo || rd_blk_en || rd_ind;

  // Read data selection; unmapped reads return zero
  assign rd_byte = rd_ch_st ? ch_st_rd[rd_ch_sel] :
                   rd_ch_en ? ch_en_rd[rd_ch_sel] :
                   rd_blk_hi ? blk_stat_hi :
                   rd_blk_lo ? blk_stat_lo :
                   rd_blk_en ? blk_en_q :
                   rd_ind ? ch_indicator : 8'h00;

  // One status/enable unit per channel
  genvar gi;
  generate
    for (gi = 0; gi < tci_pkg::CH_NUM; gi = gi + 1) begin : g_ch
      wire [5:0] evt;
      wire en_wr;
      wire st_rd;
      // Insertion pulse marks a cell sent and room freed in the buffer
      assign evt = {ext_evt[gi], ins_evt[gi], ext_ovf_evt[gi],
                    ins_ovf_evt[gi], hec_err_evt[gi], par_err_evt[gi]};
      assign en_wr = wr_ok && wr_ch_en && (wr_ch_sel == 2'(gi));
      // Clear fires on the accepting edge, so data captured shows old bits
      assign st_rd = ar_take && rd_ch_st && (rd_ch_sel == 2'(gi));
      tci_chan u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .evt(evt),
        .en_wr(en_wr),
        .en_wdata(wbyte_q[5:0]),
        .st_rd(st_rd),
        .en_rdata(ch_en_rd[gi]),
        .st_rdata(ch_st_rd[gi]),
        .chan_irq(chan_irq[gi])
      );
    end
  endgenerate

  // Channel indicator, bit n for channel n
  assign ch_indicator = {4'h0, chan_irq};

  // Transmit ATM is a source while any channel has an enabled cause
  assign tx_atm_src = |chan_irq;

  // Status byte 0 mirrors the enable layout; bits 2 and 1 stay zero
  assign blk_stat_lo = {other_blk_irq[4:1], tx_atm_src, 2'h0, other_blk_irq[0]};
  // Status byte 1 carries only the operation control flag
  assign blk_stat_hi = {op_ctrl_irq, 7'h00};

  // Writable bits only; unused bits 2 and 1 keep reading zero
  assign blk_en_d = wr_ok && wr_blk_en ? (wbyte_q & tci_pkg::BLK_EN_RW_MASK) : blk_en_q;

  // Both gates needed: block level here, source level inside each channel
  assign irq_d = |(blk_stat_lo & blk_en_q);
  assign irq = irq_q;

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_idx_q <= 16'h0000;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      aw_idx_q <= awaddr[tci_pkg::IDX_MSB:tci_pkg::IDX_LSB];
    end else if (do_wr) begin
      aw_held_q <= 1'b0;
    end
  end

  // Write data capture, address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      wbyte_q <= wdata[7:0];
      wlane_q <= wstrb[0];
    end else if (do_wr) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response raised on the same edge as the register update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= tci_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? tci_pkg::RESP_OKAY : tci_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data registered at the accepting edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= tci_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_mapped ? tci_pkg::RESP_OKAY : tci_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Block enable and interrupt registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_en_q <= tci_pkg::BLK_EN_RST;
      irq_q <= 1'b0;
    end else begin
      blk_en_q <= blk_en_d;
      irq_q <= irq_d;
    end
  end

endmodule

`default_nettype wire

// >>> tci_top_asserts.sv
// Checker for the interrupt block: bus timing and irq cause/effect
`timescale 1ns/1ps
`default_nettype none

module tci_top_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Event and level sources
  input wire logic [3:0] ext_evt,
  input wire logic [3:0] ins_evt,
  input wire logic [3:0] ext_ovf_evt,
  input wire logic [3:0] ins_ovf_evt,
  input wire logic [3:0] hec_err_evt,
  input wire logic [3:0] par_err_evt,
  input wire logic [4:0] other_blk_irq,
  // Interrupt
  input wire logic irq
);
  // Any event pulse on any channel
  wire logic any_evt = |{ext_evt, ins_evt, ext_ovf_evt, ins_ovf_evt, hec_err_evt, par_err_evt};

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence

  AST_WR_ANSWER: assert property (s_wr_taken |=> !bvalid ##1 bvalid)
    else $error("write response not two cycles after acceptance");
  AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  AST_RD_ANSWER: assert property (s_rd_taken |=> rvalid && !arready)
    else $error("read data not one cycle after acceptance");
  AST_RD_BYTE: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_R_DONE: assert property (rvalid && rready |=> !rvalid)
    else $error("read data held after handshake");
  // An irq rise needs an event, an enable write or a neighbour level
  AST_IRQ_RISE: assert property ($rose(irq) |->
    $past(bvalid) || $past(any_evt, 2) || $past(any_evt, 3) || $past(|other_blk_irq))
    else $error("irq rose without a cause");
  AST_IRQ_FALL: assert property ($fell(irq) |->
    $past(rvalid) || $past(bvalid) || $past(|other_blk_irq, 2))
    else $error("irq fell without a clear");
  AST_RESET_IDLE: assert property ($rose(aresetn) |-> !irq && !bvalid && !rvalid)
    else $error("outputs not idle after reset");
endmodule

bind tci_top tci_top_asserts chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .ext_evt(ext_evt),
  .ins_evt(ins_evt), .ext_ovf_evt(ext_ovf_evt), .ins_ovf_evt(ins_ovf_evt),
  .hec_err_evt(hec_err_evt), .par_err_evt(par_err_evt), .other_blk_irq(other_blk_irq),
  .irq(irq));

`default_nettype wire

// >>> tci_top_bench.sv
// Self-checking bench for the transmit ATM interrupt block
`timescale 1ns/1ps
`default_nettype none

module tci_top_bench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, op_ctrl_irq, irq;
  logic [31:0] awaddr, wdata, araddr, rdata, v, e;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [23:0] ev;
  logic [4:0] other_blk_irq;
  logic [7:0] blk, d;
  logic [5:0] en [4];
  logic [5:0] st [4];
  int n_fail = 0;
  int checks = 0;
  int unsigned seed = 73553;

  tci_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .ext_evt(ev[23:20]), .ins_evt(ev[19:16]),
    .ext_ovf_evt(ev[15:12]), .ins_ovf_evt(ev[11:8]), .hec_err_evt(ev[7:4]),
    .par_err_evt(ev[3:0]), .op_ctrl_irq(op_ctrl_irq), .other_blk_irq(other_blk_irq),
    .irq(irq));

  // Clock at 250 MHz
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Byte address from a register index
  function automatic logic [31:0] ba(input logic [15:0] i);
    return {14'h0, i, 2'h0};
  endfunction

  function automatic logic [7:0] ind();
    logic [7:0] x;
    x = 8'h00;
    for (int c = 0; c < 4; c++) x[c] = |(st[c] & en[c]);
    return x;
  endfunction

  function automatic logic [7:0] byte0();
    return {other_blk_irq[4:1], |ind(), 2'h0, other_blk_irq[0]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Handshakes are judged at the falling edge, where inputs and readies are settled
  task automatic wr(input logic [31:0] a, input logic [7:0] x, input logic [1:0] er);
    logic at, wt, bt;
    int k;
    bt = 1'b0;
    k = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, x};
    bready <= 1'b1;
    while (!bt && k < 50) begin
      @(negedge aclk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid;
      r = bresp;
      k++;
      @(posedge aclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      if (bt) bready <= 1'b0;
    end
    chk("bresp", {5'h0, !bt, r}, {6'h0, er});
  endtask

  task automatic rd(input string nm, input logic [31:0] a, input logic [7:0] x,
                    input logic [1:0] er);
    logic at, rt;
    int k;
    rt = 1'b0;
    k = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!rt && k < 50) begin
      @(negedge aclk);
      at = arvalid && arready;
      rt = rvalid;
      d = rdata[7:0];
      r = rresp;
      k++;
      @(posedge aclk);
      if (at) arvalid <= 1'b0;
      if (rt) rready <= 1'b0;
    end
    chk(nm, d, x);
    chk("rresp", {5'h0, !rt, r}, {6'h0, er});
  endtask

  // Main sequence: reset, register map, then random events and service passes
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, op_ctrl_irq} = 6'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hF;
    ev = 24'h000000;
    other_blk_irq = 5'h00;
    blk = 8'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd("blk_en", ba(tci_pkg::IDX_BLK_EN_LO), 8'h00, tci_pkg::RESP_OKAY);
    rd("unmapped", 32'h00000000, 8'h00, tci_pkg::RESP_SLVERR);
    wr(32'h00000004, 8'hFF, tci_pkg::RESP_SLVERR);
    wr(ba(tci_pkg::IDX_BLK_STAT_LO), 8'hFF, tci_pkg::RESP_OKAY);
    rd("stat_lo_ro", ba(tci_pkg::IDX_BLK_STAT_LO), 8'h00, tci_pkg::RESP_OKAY);
    wr(ba(tci_pkg::IDX_BLK_EN_LO), 8'hFF, tci_pkg::RESP_OKAY);
    rd("blk_en_mask", ba(tci_pkg::IDX_BLK_EN_LO), 8'hF9, tci_pkg::RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      st[c] = 6'h00;
      rd("ch_en_rst", ba({4'(c + 1), tci_pkg::IDX_CH_EN_LOW}), 8'h00, tci_pkg::RESP_OKAY);
      rd("ch_st_rst", ba({4'(c + 1), tci_pkg::IDX_CH_STAT_LOW}), 8'h00, 2'h0);
      wr(ba({4'(c + 1), tci_pkg::IDX_CH_EN_LOW}), 8'hFF, tci_pkg::RESP_OKAY);
      en[c] = 6'h3F;
      rd("ch_en_mask", ba({4'(c + 1), tci_pkg::IDX_CH_EN_LOW}), 8'h3F, 2'h0);
    end
    for (int i = 0; i < 24; i++) begin
      v = rnd();
      e = rnd() & rnd();
      wr(ba(tci_pkg::IDX_BLK_EN_LO), v[7:0], tci_pkg::RESP_OKAY);
      blk = v[7:0] & tci_pkg::BLK_EN_RW_MASK;
      wr(ba({4'(i % 4 + 1), tci_pkg::IDX_CH_EN_LOW}), v[15:8], tci_pkg::RESP_OKAY);
      en[i % 4] = v[13:8];
      @(posedge aclk);
      other_blk_irq <= v[20:16];
      op_ctrl_irq <= v[21];
      ev <= e[23:0];
      for (int c = 0; c < 4; c++)
        st[c] = st[c] | {e[20 + c], e[16 + c], e[12 + c], e[8 + c], e[4 + c], e[c]};
      @(posedge aclk);
      ev <= 24'h000000;
      repeat (4) @(negedge aclk);
      chk("irq_set", {7'h0, irq}, {7'h0, |(byte0() & blk)});
      rd("stat_hi", ba(tci_pkg::IDX_BLK_STAT_HI), {op_ctrl_irq, 7'h0}, 2'h0);
      rd("stat_lo", ba(tci_pkg::IDX_BLK_STAT_LO), byte0(), 2'h0);
      rd("chan_ind", ba(tci_pkg::IDX_CH_INDICATOR), ind(), 2'h0);
      for (int c = 0; c < 4; c++) begin
        rd("ch_st", ba({4'(c + 1), tci_pkg::IDX_CH_STAT_LOW}), {2'h0, st[c]}, 2'h0);
        st[c] = 6'h00;
      end
      repeat (4) @(negedge aclk);
      chk("irq_clr", {7'h0, irq}, {7'h0, |(byte0() & blk)});
    end
    // Insertion source alone, as software uses it when it finds the buffer full
    // Lane 0 strobe low first: the write is answered but must not land
    @(posedge aclk);
    other_blk_irq <= 5'h00;
    op_ctrl_irq <= 1'b0;
    wstrb <= 4'hE;
    wr(ba(tci_pkg::IDX_BLK_EN_LO), 8'h08, tci_pkg::RESP_OKAY);
    rd("blk_en_lane", ba(tci_pkg::IDX_BLK_EN_LO), blk, 2'h0);
    wstrb <= 4'hF;
    wr(ba(tci_pkg::IDX_BLK_EN_LO), 8'h08, tci_pkg::RESP_OKAY);
    blk = 8'h08;
    wr(ba({4'h1, tci_pkg::IDX_CH_EN_LOW}), 8'h10, tci_pkg::RESP_OKAY);
    en[0] = 6'h10;
    @(negedge aclk);
    chk("irq_idle", {7'h0, irq}, {7'h0, |(byte0() & blk)});
    @(posedge aclk);
    ev <= 24'h010000;
    st[0] = 6'h10;
    @(posedge aclk);
    ev <= 24'h000000;
    repeat (4) @(negedge aclk);
    chk("irq_ins", {7'h0, irq}, {7'h0, |(byte0() & blk)});
    rd("stat_lo_ins", ba(tci_pkg::IDX_BLK_STAT_LO), byte0(), 2'h0);
    rd("chan_ind_ins", ba(tci_pkg::IDX_CH_INDICATOR), ind(), 2'h0);
    // Reset in mid-run with irq high: irq drops, enables and status return to zero
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    blk = tci_pkg::BLK_EN_RST;
    en[0] = tci_pkg::CH_EN_RST;
    st[0] = tci_pkg::CH_ST_RST;
    @(negedge aclk);
    chk("irq_rst", {7'h0, irq}, {7'h0, |(byte0() & blk)});
    rd("blk_en_rst", ba(tci_pkg::IDX_BLK_EN_LO), blk, 2'h0);
    rd("ch_en_rst0", ba({4'h1, tci_pkg::IDX_CH_EN_LOW}), {2'h0, en[0]}, 2'h0);
    rd("ch_st_rst0", ba({4'h1, tci_pkg::IDX_CH_STAT_LOW}), {2'h0, st[0]}, 2'h0);
    stop_test();
  end

  // Watchdog well beyond the expected run of about a thousand cycles
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule

`default_nettype wire
